/* File: hdl/sfcd_decoder.sv */
`timescale 1ns/100ps
// Function
// (RULE_01) 06 sets, 04 clears write latch
// (RULE_02) 9F ident, 05 status, 01 writes status
// (RULE_03) 03 read, 0B dummy, 55 parallel
// (RULE_04) erase 20/D8, chip 60/C7, program 02
// (RULE_05) B9 power down, A5/B5 sector switch
// (RULE_06) AB release/signature, 90 maker/device
// (RULE_07) select 00 maker first, 01 device
// (RULE_08) 32 sectors of 64 KB each
// (RULE_09) unknown opcode: standby, output off
// (RULE_10) valid opcode stays active until deselect
// (RULE_11) sample on rise, shift on fall
// (RULE_12) read commands end after any bit
// (RULE_13) write commands need byte-boundary deselect
// (RULE_14) busy: array commands ignored
// (RULE_15) host polls status before commands
// (RULE_16) modify commands need write latch set
// (RULE_17) host sends latch commands alone
// (RULE_18) latch clears at reset and completions
// (RULE_19) host sends only defined opcodes
// (RULE_20) host clock idle level per polarity
// (RULE_21) busy flag set while operation runs
// (RULE_22) chip erase only with no protection
// (RULE_23) bytes most significant bit first
// (RULE_24) select fall restarts the decoder
module sfcd_decoder #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] TYPE_ID = 8'h3c, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h11, // arbitrary value
    parameter logic [7:0] SIGNATURE_ID = 8'h11 // arbitrary value
)(
    input wire logic clock, // 250 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic cs_n_pin, // chip select pin, active low
    input wire logic sclk_pin, // serial clock pin
    input wire logic si_pin, // serial data in pin
    input wire logic wp_n_pin, // write protect pin, active low
    output logic so_out, // serial data out
    output logic so_oe, // serial out enable
    output logic [23:0] rd_addr, // array byte address for reads
    input wire logic [7:0] rd_data, // array byte at rd_addr
    input wire logic op_done, // engine finished, one-cycle pulse
    input wire logic op_error, // engine error flag, level
    output sfcd_pkg::sfcd_op_t op_req, // engine request, start is a pulse
    output sfcd_pkg::sfcd_byte_t pp_data, // program data stream
    output sfcd_pkg::sfcd_status_t status, // status register
    output logic parallel_mode, // parallel mode latched until reset
    output logic extra_sector, // extra 4Kb sector selected
    output logic deep_power_down // deep power down active
);
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    sfcd_pkg::sfcd_state_t state_reg;
    sfcd_pkg::sfcd_state_t state_next;
    sfcd_pkg::sfcd_state_t addr_next;
    sfcd_pkg::sfcd_state_t opc_next;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [7:0] data_reg;
    logic [23:0] addr_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [2:0] out_bit_reg;
    logic [1:0] out_idx_reg;
    logic [7:0] out_byte;
    logic [7:0] shift_next;
    logic sclk_s, cs_n_s, si_s, wp_n_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic byte_done, len_ok, commit, out_step, is_read, hw_locked;

    // two-stage synchronisers; only the second stage feeds any logic
    always_ff @(posedge clock)
    begin
        sync1_reg <= {wp_n_pin, si_pin, cs_n_pin, sclk_pin};
        sync2_reg <= sync1_reg;
        sclk_prev_reg <= sync2_reg[0];
        cs_prev_reg <= sync2_reg[1];
    end

    assign {wp_n_s, si_s, cs_n_s, sclk_s} = sync2_reg;
    // edge detection runs off the settled copies only
    assign sclk_rise = sclk_s && !sclk_prev_reg;
    assign sclk_fall = !sclk_s && sclk_prev_reg;
    assign cs_fall = !cs_n_s && cs_prev_reg;
    assign cs_rise = cs_n_s && !cs_prev_reg;

    // (RULE_11) rise samples
    // (RULE_23) msb first shift
    assign shift_next = {shift_reg[6:0], si_s};
    assign byte_done = sclk_rise && !cs_n_s && !cs_fall && bit_cnt_reg == sfcd_pkg::BIT_LAST
        && state_reg != sfcd_pkg::ST_IGNORE;
    assign is_read = opcode_reg == sfcd_pkg::OPC_READ || opcode_reg == sfcd_pkg::OPC_FAST_READ;
    assign hw_locked = status.srwd && !wp_n_s;

    // opcode decode on the completing first byte
    always_comb
    begin
        opc_next = sfcd_pkg::ST_IGNORE;
        if (deep_power_down)
        begin
            // power down honours only the release/signature code
            opc_next = (shift_next == sfcd_pkg::OPC_RELEASE_SIG) ? sfcd_pkg::ST_ADDR : sfcd_pkg::ST_IGNORE;
        end
        else if (status.write_in_progress && shift_next != sfcd_pkg::OPC_READ_STATUS)
        begin
            // (RULE_14) busy ignores
            opc_next = sfcd_pkg::ST_IGNORE;
        end
        else
        begin
            // (RULE_01) latch codes
            // (RULE_02) ident and status codes
            // (RULE_03) read and parallel codes
            // (RULE_04) erase and program codes
            // (RULE_05) power and sector codes
            // (RULE_06) signature codes
            unique case (shift_next)
                sfcd_pkg::OPC_WRITE_ENABLE, sfcd_pkg::OPC_WRITE_DISABLE, sfcd_pkg::OPC_PARALLEL,
                sfcd_pkg::OPC_CHIP_ERASE_A, sfcd_pkg::OPC_CHIP_ERASE_B, sfcd_pkg::OPC_DEEP_POWER_DOWN,
                sfcd_pkg::OPC_ENTER_EXTRA, sfcd_pkg::OPC_EXIT_EXTRA, sfcd_pkg::OPC_WRITE_STATUS:
                    opc_next = sfcd_pkg::ST_IN;
                sfcd_pkg::OPC_READ_IDENT, sfcd_pkg::OPC_READ_STATUS:
                    opc_next = sfcd_pkg::ST_OUT;
                sfcd_pkg::OPC_READ, sfcd_pkg::OPC_FAST_READ, sfcd_pkg::OPC_SECTOR_ERASE_A,
                sfcd_pkg::OPC_SECTOR_ERASE_B, sfcd_pkg::OPC_PAGE_PROGRAM, sfcd_pkg::OPC_RELEASE_SIG,
                sfcd_pkg::OPC_MAKER_DEVICE:
                    opc_next = sfcd_pkg::ST_ADDR;
                // (RULE_09) unknown code
                default:
                    opc_next = sfcd_pkg::ST_IGNORE;
            endcase
        end
    end

    // where a command goes after its third address byte
    assign addr_next = (opcode_reg == sfcd_pkg::OPC_FAST_READ) ? sfcd_pkg::ST_DUMMY
        : (opcode_reg == sfcd_pkg::OPC_PAGE_PROGRAM || opcode_reg == sfcd_pkg::OPC_SECTOR_ERASE_A
        || opcode_reg == sfcd_pkg::OPC_SECTOR_ERASE_B) ? sfcd_pkg::ST_IN : sfcd_pkg::ST_OUT;

    // state walk; no path back to the opcode state except a select fall
    // (RULE_10) active until deselect
    always_comb
    begin
        state_next = state_reg;
        if (cs_fall)
            // (RULE_24) fresh frame
            state_next = sfcd_pkg::ST_OPCODE;
        else if (byte_done)
        begin
            unique case (state_reg)
                sfcd_pkg::ST_OPCODE: state_next = opc_next;
                sfcd_pkg::ST_ADDR: state_next = (byte_cnt_reg == sfcd_pkg::LEN_ADDR_LAST) ? addr_next : state_reg;
                sfcd_pkg::ST_DUMMY: state_next = sfcd_pkg::ST_OUT;
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_reg <= sfcd_pkg::ST_IGNORE; // wait for a clean frame start
        else
            state_reg <= state_next;
    end

    // bit and byte counters, input shift, captured bytes
    always_ff @(posedge clock)
    begin
        if (reset || cs_fall)
        begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end
        else if (sclk_rise && !cs_n_s)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= shift_next;
            // saturate so long program bursts keep a valid count
            if (byte_done && byte_cnt_reg != 3'h7)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            opcode_reg <= 8'h00;
            data_reg <= 8'h00;
        end
        else if (byte_done)
        begin
            if (state_reg == sfcd_pkg::ST_OPCODE)
                opcode_reg <= shift_next;
            if (state_reg == sfcd_pkg::ST_IN)
                data_reg <= shift_next;
        end
    end

    // address: shifted in high byte first, then stepped per read byte
    always_ff @(posedge clock)
    begin
        if (reset)
            addr_reg <= 24'h000000;
        else if (byte_done && state_reg == sfcd_pkg::ST_ADDR)
            addr_reg <= {addr_reg[15:0], shift_next};
        else if (out_step && is_read)
            addr_reg <= (addr_reg + sfcd_pkg::ADDR_STEP) & sfcd_pkg::ARRAY_MASK; // wraps at array end
    end
    assign rd_addr = addr_reg;

    // (RULE_13) byte boundary lengths
    assign len_ok = (opcode_reg == sfcd_pkg::OPC_WRITE_STATUS) ? byte_cnt_reg == sfcd_pkg::LEN_WRITE_STATUS
        : (opcode_reg == sfcd_pkg::OPC_SECTOR_ERASE_A || opcode_reg == sfcd_pkg::OPC_SECTOR_ERASE_B)
        ? byte_cnt_reg == sfcd_pkg::LEN_ADDRESSED
        : (opcode_reg == sfcd_pkg::OPC_PAGE_PROGRAM) ? byte_cnt_reg >= sfcd_pkg::LEN_PROGRAM_MIN
        : byte_cnt_reg == sfcd_pkg::LEN_SINGLE;
    assign commit = cs_rise && bit_cnt_reg == 3'h0 && len_ok
        && (state_reg == sfcd_pkg::ST_IN || state_reg == sfcd_pkg::ST_ADDR);

    // status register and mode flags, changed at commit or by the engine
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            status <= '0;
            parallel_mode <= 1'b0;
            extra_sector <= 1'b0;
            deep_power_down <= 1'b0;
        end
        else
        begin
            status.error <= op_error;
            if (op_done && status.write_in_progress)
            begin
                // (RULE_18) completion clears
                // (RULE_21) busy ends
                status.write_in_progress <= 1'b0;
                status.write_enable_latch <= 1'b0;
            end
            if (commit)
            begin
                unique case (opcode_reg)
                    // (RULE_01) latch set/clear
                    sfcd_pkg::OPC_WRITE_ENABLE: status.write_enable_latch <= 1'b1;
                    sfcd_pkg::OPC_WRITE_DISABLE: status.write_enable_latch <= 1'b0;
                    // (RULE_03) parallel sticks
                    sfcd_pkg::OPC_PARALLEL: parallel_mode <= 1'b1;
                    // (RULE_05) power and sector
                    sfcd_pkg::OPC_DEEP_POWER_DOWN: deep_power_down <= 1'b1;
                    sfcd_pkg::OPC_ENTER_EXTRA: extra_sector <= 1'b1;
                    sfcd_pkg::OPC_EXIT_EXTRA: extra_sector <= 1'b0;
                    // (RULE_06) release power down
                    sfcd_pkg::OPC_RELEASE_SIG: deep_power_down <= 1'b0;
                    // (RULE_02) status write
                    // (RULE_16) latch required
                    sfcd_pkg::OPC_WRITE_STATUS:
                    begin
                        if (status.write_enable_latch && !hw_locked)
                        begin
                            status.srwd <= data_reg[7];
                            status.bp <= data_reg[4:2];
                            status.write_in_progress <= 1'b1;
                        end
                    end
                    sfcd_pkg::OPC_CHIP_ERASE_A, sfcd_pkg::OPC_CHIP_ERASE_B:
                        // (RULE_22) unprotected only
                        status.write_in_progress <= status.write_enable_latch && status.bp == sfcd_pkg::BP_NONE;
                    sfcd_pkg::OPC_SECTOR_ERASE_A, sfcd_pkg::OPC_SECTOR_ERASE_B, sfcd_pkg::OPC_PAGE_PROGRAM:
                        // (RULE_21) busy starts
                        status.write_in_progress <= status.write_enable_latch;
                    default: ;
                endcase
            end
        end
    end

    // engine request and program data; a start fires only while busy gets set
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            op_req <= '0;
            pp_data <= '0;
        end
        else
        begin
            op_req.start <= 1'b0;
            pp_data.valid <= byte_done && state_reg == sfcd_pkg::ST_IN && status.write_enable_latch
                && opcode_reg == sfcd_pkg::OPC_PAGE_PROGRAM;
            pp_data.data <= shift_next;
            if (commit && status.write_enable_latch && !status.write_in_progress)
            begin
                op_req.addr <= addr_reg;
                // (RULE_08) sector index
                op_req.sector <= addr_reg[sfcd_pkg::SECTOR_LSB +: sfcd_pkg::SECTOR_W];
                unique case (opcode_reg)
                    sfcd_pkg::OPC_WRITE_STATUS:
                    begin
                        op_req.start <= !hw_locked;
                        op_req.kind <= sfcd_pkg::OP_WRITE_STATUS;
                    end
                    sfcd_pkg::OPC_PAGE_PROGRAM:
                    begin
                        op_req.start <= 1'b1;
                        op_req.kind <= sfcd_pkg::OP_PROGRAM;
                    end
                    sfcd_pkg::OPC_SECTOR_ERASE_A, sfcd_pkg::OPC_SECTOR_ERASE_B:
                    begin
                        op_req.start <= 1'b1;
                        op_req.kind <= sfcd_pkg::OP_SECTOR_ERASE;
                    end
                    sfcd_pkg::OPC_CHIP_ERASE_A, sfcd_pkg::OPC_CHIP_ERASE_B:
                    begin
                        op_req.start <= status.bp == sfcd_pkg::BP_NONE;
                        op_req.kind <= sfcd_pkg::OP_CHIP_ERASE;
                    end
                    default: ;
                endcase
            end
        end
    end

    // (RULE_07) select byte order
    always_comb
    begin
        out_byte = rd_data;
        if (opcode_reg == sfcd_pkg::OPC_READ_IDENT)
            out_byte = (out_idx_reg == 2'h0) ? MAKER_ID : (out_idx_reg == 2'h1) ? TYPE_ID : DEVICE_ID;
        else if (opcode_reg == sfcd_pkg::OPC_READ_STATUS)
            out_byte = status;
        else if (opcode_reg == sfcd_pkg::OPC_RELEASE_SIG)
            out_byte = SIGNATURE_ID;
        else if (opcode_reg == sfcd_pkg::OPC_MAKER_DEVICE)
            out_byte = (out_idx_reg[0] ^ addr_reg[0]) ? DEVICE_ID : MAKER_ID;
    end

    // (RULE_11) fall shifts out
    assign out_step = sclk_fall && !cs_n_s && state_reg == sfcd_pkg::ST_OUT && out_bit_reg == sfcd_pkg::BIT_LAST;
    always_ff @(posedge clock)
    begin
        if (reset || cs_fall)
        begin
            out_bit_reg <= 3'h0;
            out_idx_reg <= 2'h0;
            so_out <= 1'b0;
        end
        else if (sclk_fall && !cs_n_s && state_reg == sfcd_pkg::ST_OUT)
        begin
            so_out <= out_byte[~out_bit_reg]; // msb first
            out_bit_reg <= out_bit_reg + 3'h1;
            if (out_step)
                out_idx_reg <= (out_idx_reg == sfcd_pkg::IDENT_LAST) ? 2'h0 : out_idx_reg + 2'h1;
        end
    end

    // (RULE_12) deselect ends output
    always_ff @(posedge clock)
    begin
        if (reset || cs_n_s || state_reg != sfcd_pkg::ST_OUT)
            so_oe <= 1'b0;
        else if (sclk_fall)
            so_oe <= 1'b1;
    end

    // checks
    a_ignore_hiz: assert property (@(posedge clock) disable iff (reset) // RULE_09
        state_reg == sfcd_pkg::ST_IGNORE |=> !so_oe) else $error("output driven in standby");
    a_ignore_holds: assert property (@(posedge clock) disable iff (reset) // RULE_09
        state_reg == sfcd_pkg::ST_IGNORE && !cs_fall |=> state_reg == sfcd_pkg::ST_IGNORE)
        else $error("left standby without select fall");
    a_active_holds: assert property (@(posedge clock) disable iff (reset) // RULE_10
        state_reg != sfcd_pkg::ST_OPCODE && state_reg != sfcd_pkg::ST_IGNORE && !cs_fall
        |=> state_reg != sfcd_pkg::ST_OPCODE && state_reg != sfcd_pkg::ST_IGNORE)
        else $error("active command dropped");
    a_fall_fresh: assert property (@(posedge clock) disable iff (reset) // RULE_24
        cs_fall |=> state_reg == sfcd_pkg::ST_OPCODE && bit_cnt_reg == 3'h0 && byte_cnt_reg == 3'h0)
        else $error("frame did not restart");
    a_write_enable_cmd_sets: assert property (@(posedge clock) disable iff (reset) // RULE_01
        commit && opcode_reg == sfcd_pkg::OPC_WRITE_ENABLE |=> status.write_enable_latch) else $error("latch not set");
    a_done_clears: assert property (@(posedge clock) disable iff (reset) // RULE_18
        op_done && status.write_in_progress |=> !status.write_enable_latch && !status.write_in_progress) else $error("completion left latch set");
    a_start_needs: assert property (@(posedge clock) disable iff (reset) // RULE_16
        op_req.start |-> $past(status.write_enable_latch, 1) && status.write_in_progress) else $error("operation without latch");
    a_boundary_reject: assert property (@(posedge clock) disable iff (reset) // RULE_13
        cs_rise && bit_cnt_reg != 3'h0 |=> !op_req.start && $stable(status.write_enable_latch))
        else $error("partial byte executed");
    a_chip_protect: assert property (@(posedge clock) disable iff (reset) // RULE_22
        op_req.start && op_req.kind == sfcd_pkg::OP_CHIP_ERASE |-> status.bp == sfcd_pkg::BP_NONE)
        else $error("chip erase while protected");
    a_busy_ignore: assert property (@(posedge clock) disable iff (reset) // RULE_14
        byte_done && state_reg == sfcd_pkg::ST_OPCODE && status.write_in_progress && shift_next != sfcd_pkg::OPC_READ_STATUS
        |=> state_reg == sfcd_pkg::ST_IGNORE) else $error("busy accepted a command");
    a_out_on_fall: assert property (@(posedge clock) disable iff (reset) // RULE_11
        so_oe && $past(so_oe) && !$stable(so_out) |-> $past(sclk_fall)) else $error("output moved off falling edge");
    c_read_frame: cover property (@(posedge clock) disable iff (reset) out_step && is_read);
    c_write_enable_cmd: cover property (@(posedge clock) disable iff (reset) commit && opcode_reg == sfcd_pkg::OPC_WRITE_ENABLE);
    c_program: cover property (@(posedge clock) disable iff (reset) op_req.start && op_req.kind == sfcd_pkg::OP_PROGRAM);
    c_ignore: cover property (@(posedge clock) disable iff (reset) byte_done ##1 state_reg == sfcd_pkg::ST_IGNORE);
endmodule

/* File: shared/sfcd_pkg.sv */
package sfcd_pkg;
    // one-byte command codes
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_IDENT = 8'h9f;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_FAST_READ = 8'h0b;
    localparam logic [7:0] OPC_PARALLEL = 8'h55;
    localparam logic [7:0] OPC_SECTOR_ERASE_A = 8'h20;
    localparam logic [7:0] OPC_SECTOR_ERASE_B = 8'hd8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_DEEP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OPC_ENTER_EXTRA = 8'ha5;
    localparam logic [7:0] OPC_EXIT_EXTRA = 8'hb5;
    localparam logic [7:0] OPC_RELEASE_SIG = 8'hab;
    localparam logic [7:0] OPC_MAKER_DEVICE = 8'h90;

    // frame lengths in bytes, opcode included
    localparam logic [2:0] LEN_SINGLE = 3'h1;
    localparam logic [2:0] LEN_WRITE_STATUS = 3'h2;
    localparam logic [2:0] LEN_ADDRESSED = 3'h4;
    localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
    localparam logic [2:0] LEN_ADDR_LAST = 3'h3; // byte count when the last address byte completes
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] IDENT_LAST = 2'h2; // three identification bytes, then repeat

    // array map: 32 sectors of 64 KB over 21 address bits
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_W = 5;
    localparam logic [23:0] ARRAY_MASK = 24'h1fffff;
    localparam logic [23:0] ADDR_STEP = 24'h000001;
    localparam logic [2:0] BP_NONE = 3'h0;

    // decoder states, one-hot
    typedef enum logic [5:0] {
        ST_OPCODE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_DUMMY = 6'b000100,
        ST_IN = 6'b001000,
        ST_OUT = 6'b010000,
        ST_IGNORE = 6'b100000
    } sfcd_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WRITE_STATUS = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_SECTOR_ERASE = 3'h3,
        OP_CHIP_ERASE = 3'h4
    } sfcd_op_kind_t;

    // request to the program/erase engine
    typedef struct packed {
        logic start;
        sfcd_op_kind_t kind;
        logic [23:0] addr;
        logic [SECTOR_W-1:0] sector;
    } sfcd_op_t;

    // one page-program data byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfcd_byte_t;

    // status byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic srwd;
        logic error;
        logic zero;
        logic [2:0] bp;
        logic write_enable_latch;
        logic write_in_progress;
    } sfcd_status_t;
endpackage

/* File: verification/sfcd_host_model.sv */
`timescale 1ns/100ps
module sfcd_host_model (
    output logic cs_n, // chip select, active low
    output logic sclk, // serial clock
    output logic si, // data to the device
    input wire logic so_out, // data from the device
    input wire logic so_oe // device drives so
);
    logic idle_hi; // clock level between frames
    logic so_seen; // level the host reads off the so wire
    // deselected at time zero
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        so_seen = 1'b0;
        idle_hi = 1'b0;
    end
    task automatic beg(input logic m);
        idle_hi = m;
        sclk = m;
        #100 cs_n = 1'b0;
        #100;
    endtask
    // shift on fall, sample on rise
    task automatic bits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sclk = 1'b0;
            si = b[i];
            #62.5 sclk = 1'b1;
            // an undriven wire reads back inverted so a stale bit never passes
            so_seen = so_oe ? so_out : ~so_seen;
            r = {r[6:0], so_seen};
            #62.5;
        end
    endtask
    // deselect only after the last bit
    task automatic fin();
        if (!idle_hi)
            sclk = 1'b0;
        #62.5 cs_n = 1'b1;
        si = ~si;
        #200;
    endtask
endmodule

/* File: verification/sfcd_decoder_tb.sv */
`timescale 1ns/100ps
module sfcd_decoder_tb;
    localparam logic [7:0] MK = 8'h4e, TY = 8'h27, DV = 8'h61, SG = 8'h72; // arbitrary values
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic op_done = 1'b0;
    logic wp_n = 1'b1;
    logic [7:0] rd_data = 8'h00;
    wire logic cs_n_pin, sclk_pin, si_pin;
    logic so_out, so_oe, parallel_mode, extra_sector, deep_power_down, oe_seen;
    logic [23:0] rd_addr, rx;
    logic [7:0] last_pp;
    sfcd_pkg::sfcd_op_t op_req, last_op;
    sfcd_pkg::sfcd_byte_t pp_data;
    sfcd_pkg::sfcd_status_t status;
    int miscompares = 0, num_checks = 0, n_ops = 0, cycles = 0;
    sfcd_decoder #(.MAKER_ID(MK), .TYPE_ID(TY), .DEVICE_ID(DV), .SIGNATURE_ID(SG)) uut (
        .clock, .reset, .cs_n_pin, .sclk_pin, .si_pin, .wp_n_pin(wp_n), .so_out, .so_oe,
        .rd_addr, .rd_data, .op_done, .op_error(1'b0), .op_req, .pp_data, .status,
        .parallel_mode, .extra_sector, .deep_power_down);
    sfcd_host_model host (.cs_n(cs_n_pin), .sclk(sclk_pin), .si(si_pin), .so_out, .so_oe);
    // 250 MHz
    initial
    begin
        forever #2 clock = ~clock;
    end
    // array contents are a simple function of the address
    function automatic logic [7:0] arr(input logic [23:0] a);
        return a[7:0] ^ a[23:16];
    endfunction
    always @(negedge clock) rd_data <= arr(rd_addr);
    // engine side capture and hang guard
    always @(posedge clock)
    begin
        if (op_req.start)
        begin
            last_op <= op_req;
            n_ops <= n_ops + 1;
        end
        if (pp_data.valid)
            last_pp <= pp_data.data;
        if (so_oe)
            oe_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic frame(input logic m, input logic [39:0] tx, input int nb, input int rd, input int xb);
        logic [7:0] r;
        rx = 24'h0;
        host.beg(m);
        for (int i = nb - 1; i >= 0; i--)
            host.bits(tx[8*i +: 8], 8, r);
        for (int i = 0; i < rd; i++)
        begin
            host.bits(8'h00, 8, r);
            rx = {rx[15:0], r};
        end
        if (xb > 0)
            host.bits(8'hff, xb, r);
        host.fin();
    endtask
    task automatic done_pulse();
        @(negedge clock) op_done = 1'b1;
        @(negedge clock) op_done = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // main sequence; defined opcodes only, bar one standby probe
    initial
    begin
        repeat (10) @(negedge clock);
        reset = 1'b0;
        repeat (5) @(negedge clock);
        chk("status", 24'h0, 24'(status)); // clear after reset
        frame(0, 40'h06, 1, 0, 0);
        chk("wel", 24'h1, 24'(status.write_enable_latch)); // set in mode 0
        frame(1, 40'h04, 1, 0, 0);
        chk("wel", 24'h0, 24'(status.write_enable_latch)); // clear in mode 3
        frame(0, 40'h06, 1, 0, 1);
        chk("wel", 24'h0, 24'(status.write_enable_latch)); // ragged end refused
        frame(1, 40'h06, 1, 0, 0);
        frame(1, 40'h05, 1, 2, 3);
        chk("status read", 24'h0202, rx); // repeated status
        frame(0, 40'h9f, 1, 3, 0);
        chk("ident", {MK, TY, DV}, rx); // ident bytes
        frame(0, 40'h9f, 1, 0, 3);
        frame(0, 40'hab000000, 4, 1, 0);
        chk("signature", 24'(SG), rx); // fresh frame
        for (int s = 0; s < 2; s++)
        begin
            frame(1'(s), {8'h90, 16'h0, 8'(s)}, 4, 2, 0);
            chk("maker device", s ? {8'h0, DV, MK} : {8'h0, MK, DV}, rx); // order
        end
        $display("id tests done");
        frame(0, 40'h0310ffff, 4, 2, 0);
        chk("read", {8'h0, arr(24'h10ffff), arr(24'h110000)}, rx); // sector step
        frame(1, 40'h0b1ffffe, 4, 4, 0);
        chk("fast read", {arr(24'h1ffffe), arr(24'h1fffff), arr(24'h0)}, rx); // dummy, wrap
        oe_seen = 1'b0;
        frame(0, 40'hff05, 2, 1, 0);
        chk("so enable", 24'h0, 24'(oe_seen)); // unknown opcode
        $display("read tests done");
        frame(0, 40'h04, 1, 0, 0);
        frame(0, 40'h2010ffff, 4, 0, 0);
        chk("requests", 24'h0, 24'(n_ops)); // no latch no erase
        frame(0, 40'h06, 1, 0, 0);
        frame(0, 40'hd810ffff, 4, 0, 0);
        chk("erase", 24'({sfcd_pkg::OP_SECTOR_ERASE, 5'h10}), 24'({last_op.kind, last_op.sector}));
        chk("erase addr", 24'h10ffff, last_op.addr); // address order
        chk("wip", 24'h1, 24'(status.write_in_progress)); // busy while running
        oe_seen = 1'b0;
        frame(0, 40'h9f, 1, 1, 0);
        chk("so enable", 24'h0, 24'(oe_seen)); // ignored while busy
        done_pulse();
        chk("status", 24'h0, 24'(status)); // cleared on done
        frame(0, 40'h05, 1, 1, 0);
        chk("poll", 24'h0, rx); // ready again
        frame(1, 40'h06, 1, 0, 0);
        frame(1, 40'hc7, 1, 0, 0);
        chk("chip erase", 24'(sfcd_pkg::OP_CHIP_ERASE), 24'(last_op.kind));
        done_pulse();
        frame(0, 40'h06, 1, 0, 0);
        frame(0, 40'h02000100a7, 5, 0, 0);
        chk("program", 24'({sfcd_pkg::OP_PROGRAM, 8'ha7}), 24'({last_op.kind, last_pp})); // data
        done_pulse();
        frame(0, 40'h06, 1, 0, 0);
        frame(0, 40'h019c, 2, 0, 0);
        chk("status op", 24'(sfcd_pkg::OP_WRITE_STATUS), 24'(last_op.kind));
        done_pulse();
        chk("status", 24'h9c, 24'(status));
        frame(1, 40'h06, 1, 0, 0);
        frame(1, 40'h60, 1, 0, 0);
        chk("requests", 24'h4, 24'(n_ops)); // protected
        wp_n = 1'b0;
        frame(0, 40'h0100, 2, 0, 0);
        chk("locked", 24'h9e, 24'(status));
        wp_n = 1'b1;
        frame(0, 40'h0100, 2, 0, 0);
        done_pulse();
        chk("status", 24'h0, 24'(status));
        $display("write tests done");
        for (int k = 0; k < 5; k++)
        begin
            frame(1'(k), {32'h0, 8'(40'hb9aba5b555 >> (32 - 8 * k))}, 1, 0, 0);
            chk("modes", 24'(15'h1084 >> (12 - 3 * k)) & 24'h7, 24'({parallel_mode, extra_sector, deep_power_down}));
        end
        $display("mode tests done");
        close_out();
    end
endmodule
